//--- alarm_panel.sv
// Functional notes
// RULE1: Full-scale low alarm below threshold, high alarm above threshold.
// RULE2: Deviation low/high alarm when value differs from setpoint beyond threshold.
// RULE3: Band alarm when absolute deviation from setpoint exceeds threshold.
// RULE4: Rate alarms compare per-minute rise or fall against threshold.
// RULE5: Loop broken when value stays unchanged too long after output change.
// RULE6: Open sensor raises break alarm and forces output to safe level.
// RULE7: New alarm flashes beacon, shows its source, operates assigned outputs.
// RULE8: Each relay selects energised or de-energised while in alarm.
// RULE9: Acknowledge makes beacon steady if any alarm remains, else off.
// RULE10: Non-latching alarm clears itself when condition goes.
// RULE11: Auto-latching needs condition gone and acknowledge; early acknowledge remembered.
// RULE12: Manual-latching clears only on acknowledge after condition gone.
// RULE13: Reset gives non-latching alarms, relays de-energised in alarm.
// RULE14: Enabled remote setpoint with open input lights the beacon.
// RULE15: Output indicators follow outputs; alternate setpoint indicator when not primary.
// RULE16: Remote indicator lit for remote setpoint, flashes with comms activity.
// RULE17: Run indicator steady running, flashing held; manual indicator in manual.
// RULE18: Manual: operator sets output, band/deviation masked, tune/timer disabled.
// RULE19: Off: heat/cool off, process alarms live, band/deviation held off.
// RULE20: Page and scroll held over one second from home enter mode selection.
// RULE21: Lower steps Auto, Manual, Off; two idle seconds apply and return home.
// RULE22: Auto to manual holds output; manual to auto ramps toward demand.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module alarm_panel
	import panel_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter int RATE_TICKS = RATE_TICKS_DEF
)
(
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] PROCESS_VALUE,
	input wire logic [15:0] SETPOINT_VALUE,
	input wire logic [15:0] AUTO_DEMAND,
	input wire logic SENSOR_OPEN,
	input wire logic REMOTE_INPUT_OPEN,
	input wire logic [3:0] OUTPUT_ON,
	input wire logic ALT_SETPOINT_IN_USE,
	input wire logic REMOTE_SETPOINT_IN_USE,
	input wire logic COMMS_ACTIVE,
	input wire logic TIMER_RUNNING,
	input wire logic TIMER_HELD,
	input wire logic HOME_DISPLAY,
	input wire logic BTN_PAGE,
	input wire logic BTN_SCROLL,
	input wire logic BTN_RAISE,
	input wire logic BTN_LOWER,
	output logic ALARM_BEACON,
	output logic [3:0] ALARM_RELAY,
	output logic [3:0] ALARM_SOURCE,
	output logic LOOP_BREAK_MESSAGE,
	output logic SENSOR_BREAK_MESSAGE,
	output logic OUTPUT_ONE_INDICATOR,
	output logic OUTPUT_TWO_INDICATOR,
	output logic OUTPUT_THREE_INDICATOR,
	output logic OUTPUT_FOUR_INDICATOR,
	output logic ALT_SETPOINT_INDICATOR,
	output logic REMOTE_SETPOINT_INDICATOR,
	output logic RUN_INDICATOR,
	output logic MANUAL_INDICATOR,
	output logic MODE_SELECT_DISPLAY,
	output logic [2:0] LOOP_MODE,
	output logic [15:0] WORKING_OUTPUT,
	output logic HEAT_COOL_ENABLE,
	output logic RETRANSMIT_ENABLE,
	output logic TUNE_TIMER_ENABLE
);
	logic [31:0] ctrl;
	logic [15:0] loop_delay;
	logic [31:0] alm_cfg [ALARM_COUNT];
	logic sw_ack;
	logic [31:0] tick_cnt;
	logic tick;
	logic [15:0] flash_cnt;
	logic blink;
	logic [3:0] btn_prev;
	logic chord_prev;
	logic ack;
	panel_state_type state;
	mode_type mode;
	mode_type pending;
	logic [15:0] sel_cnt;
	logic ramping;
	logic [15:0] pv_prev;
	logic [15:0] out_prev;
	logic [15:0] lb_cnt;
	logic lb_armed;
	logic loop_break;
	logic sensor_prev;
	logic loop_prev;
	logic [31:0] rate_cnt;
	logic [15:0] rate_base;
	logic signed [17:0] rate_delta;
	logic [3:0] cond;
	logic [3:0] active;
	logic [3:0] new_alarm;
	logic flashing;
	logic any_new;
	logic any_active;
	logic chord;
	logic [3:0] btn_edge;
	logic signed [17:0] dev;

	assign chord = BTN_PAGE && BTN_SCROLL;
	assign btn_edge = {BTN_PAGE, BTN_SCROLL, BTN_RAISE, BTN_LOWER} & ~btn_prev;
	assign ack = (chord && !chord_prev) || sw_ack;
	assign dev = sdiff(PROCESS_VALUE, SETPOINT_VALUE);
	assign any_active = (|active) || loop_break || SENSOR_OPEN;
	assign any_new = (|new_alarm) || (SENSOR_OPEN && !sensor_prev) || (loop_break && !loop_prev);

	// ********************************
	// APB register slave
	// ********************************
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			ctrl <= CTRL_RESET;
			loop_delay <= LOOP_DELAY_RESET;
			for (int i = 0; i < ALARM_COUNT; i++)
				alm_cfg[i] <= ALM_CFG_RESET; // [RULE13]
			sw_ack <= 1'b0;
		end
		else
		begin
			sw_ack <= 1'b0;
			if (PSEL && PENABLE && PWRITE)
			begin
				if (PADDR == ADDR_CTRL)
					ctrl <= PWDATA;
				if (PADDR == ADDR_LOOP_DELAY)
					loop_delay <= PWDATA[15:0];
				if (PADDR == ADDR_STATUS)
					sw_ack <= PWDATA[STATUS_ACK_BIT];
				for (int i = 0; i < ALARM_COUNT; i++)
					if (PADDR == ADDR_ALARM_BASE + 8'(4 * i))
						alm_cfg[i] <= PWDATA;
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			PREADY <= 1'b0;
		end
		else
		begin
			PREADY <= 1'b1;
			if (PSEL && !PENABLE)
			begin
				PSLVERR <= 1'b0;
				PRDATA <= 32'h0000_0000;
				unique case (PADDR)
					ADDR_CTRL: PRDATA <= ctrl;
					ADDR_LOOP_DELAY: PRDATA <= {16'h0000, loop_delay};
					ADDR_STATUS: PRDATA <= {20'h00000, state, mode, SENSOR_OPEN, loop_break, active};
					ADDR_OUTPUT: PRDATA <= {16'h0000, WORKING_OUTPUT};
					ADDR_ALARM_BASE: PRDATA <= alm_cfg[0];
					ADDR_ALARM_BASE + 8'h04: PRDATA <= alm_cfg[1];
					ADDR_ALARM_BASE + 8'h08: PRDATA <= alm_cfg[2];
					ADDR_ALARM_BASE + 8'h0c: PRDATA <= alm_cfg[3];
					default: PSLVERR <= 1'b1;
				endcase
			end
		end
	end

	// ********************************
	// Time base and blink
	// ********************************
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST || tick_cnt == 32'(TICK_CYCLES - 1))
			tick_cnt <= 32'h0000_0000;
		else
			tick_cnt <= tick_cnt + 32'h0000_0001;
	end
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			flash_cnt <= 16'h0000;
			blink <= 1'b0;
		end
		else if (tick)
		begin
			flash_cnt <= (flash_cnt == FLASH_TICKS - 16'h0001) ? 16'h0000 : flash_cnt + 16'h0001;
			if (flash_cnt == FLASH_TICKS - 16'h0001)
				blink <= !blink;
		end
	end

	// ********************************
	// Alarm conditions
	// ********************************
	always_comb
	begin
		for (int i = 0; i < ALARM_COUNT; i++)
		begin
			logic signed [17:0] thr;
			thr = sext(alm_cfg[i][15:0]);
			unique case (alarm_kind_type'(alm_cfg[i][ALM_TYPE_LSB +: 3]))
				AL_HIGH: cond[i] = sext(PROCESS_VALUE) > thr; // [RULE1]
				AL_LOW: cond[i] = sext(PROCESS_VALUE) < thr; // [RULE1]
				AL_DEV_HIGH: cond[i] = (mode == MODE_AUTO) && (dev > thr); // [RULE2] [RULE18] [RULE19]
				AL_DEV_LOW: cond[i] = (mode == MODE_AUTO) && (-dev > thr); // [RULE2] [RULE18] [RULE19]
				AL_BAND: cond[i] = (mode == MODE_AUTO) && (dev > thr || -dev > thr); // [RULE3] [RULE18]
				AL_RISE: cond[i] = rate_delta > thr; // [RULE4]
				AL_FALL: cond[i] = -rate_delta > thr; // [RULE4]
				AL_NONE: cond[i] = 1'b0;
			endcase
		end
	end

	for (genvar g = 0; g < ALARM_COUNT; g++)
	begin : g_alarm
		alarm_latch u_latch (
			.clk(CLK_SYS),
			.rst(SYS_RST),
			.cond(cond[g]),
			.ack(ack),
			.latch_mode(alm_cfg[g][ALM_LATCH_LSB +: 2]),
			.active(active[g]),
			.new_alarm(new_alarm[g])
		);
	end

	// Rate is the change over one minute window of ticks
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			rate_cnt <= 32'h0000_0000;
			rate_base <= 16'h0000;
			rate_delta <= 18'sh00000;
		end
		else if (tick)
		begin
			rate_cnt <= rate_cnt + 32'h0000_0001;
			if (rate_cnt == 32'(RATE_TICKS - 1))
			begin
				rate_cnt <= 32'h0000_0000;
				rate_delta <= sdiff(PROCESS_VALUE, rate_base); // [RULE4]
				rate_base <= PROCESS_VALUE;
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			pv_prev <= 16'h0000;
			out_prev <= 16'h0000;
			lb_cnt <= 16'h0000;
			lb_armed <= 1'b0;
			loop_break <= 1'b0;
		end
		else
		begin
			pv_prev <= PROCESS_VALUE;
			out_prev <= WORKING_OUTPUT;
			if (PROCESS_VALUE != pv_prev)
			begin
				lb_armed <= 1'b0;
				loop_break <= 1'b0;
			end
			else if (WORKING_OUTPUT != out_prev)
			begin
				lb_armed <= 1'b1;
				lb_cnt <= 16'h0000;
			end
			else if (lb_armed && tick)
			begin
				lb_cnt <= lb_cnt + 16'h0001;
				if (lb_cnt + 16'h0001 >= loop_delay)
				begin
					loop_break <= 1'b1; // [RULE5]
					lb_armed <= 1'b0;
				end
			end
		end
	end

	// ********************************
	// Beacon, relays and messages
	// ********************************
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			flashing <= 1'b0;
			sensor_prev <= 1'b0;
			loop_prev <= 1'b0;
		end
		else
		begin
			sensor_prev <= SENSOR_OPEN;
			loop_prev <= loop_break;
			if (any_new)
				flashing <= 1'b1; // [RULE7]
			else if (ack || !any_active)
				flashing <= 1'b0; // [RULE9]
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			ALARM_BEACON <= 1'b0;
			ALARM_RELAY <= 4'h0;
			ALARM_SOURCE <= 4'h0;
			LOOP_BREAK_MESSAGE <= 1'b0;
			SENSOR_BREAK_MESSAGE <= 1'b0;
		end
		else
		begin
			ALARM_BEACON <= (flashing && blink) || (!flashing && any_active) // [RULE7] [RULE9]
				|| (ctrl[CTRL_REMOTE_EN_BIT] && REMOTE_INPUT_OPEN); // [RULE14]
			for (int i = 0; i < ALARM_COUNT; i++)
				ALARM_RELAY[i] <= active[i] ~^ alm_cfg[i][ALM_ENERGISE_BIT]; // [RULE7] [RULE8]
			ALARM_SOURCE <= active; // [RULE7]
			LOOP_BREAK_MESSAGE <= loop_break; // [RULE5]
			SENSOR_BREAK_MESSAGE <= SENSOR_OPEN; // [RULE6]
		end
	end

	// ********************************
	// Mode selection
	// ********************************
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			state <= ST_HOME;
			mode <= MODE_AUTO;
			pending <= MODE_AUTO;
			sel_cnt <= 16'h0000;
			btn_prev <= 4'h0;
			chord_prev <= 1'b0;
		end
		else
		begin
			btn_prev <= {BTN_PAGE, BTN_SCROLL, BTN_RAISE, BTN_LOWER};
			chord_prev <= chord;
			unique case (state)
				ST_HOME:
					if (chord && HOME_DISPLAY)
					begin
						state <= ST_HOLD; // [RULE20]
						sel_cnt <= 16'h0000;
					end
				ST_HOLD:
					if (!chord)
						state <= ST_HOME;
					else if (tick)
					begin
						sel_cnt <= sel_cnt + 16'h0001;
						if (sel_cnt >= HOLD_TICKS)
						begin
							state <= ST_SELECT; // [RULE20]
							pending <= mode;
							sel_cnt <= 16'h0000;
						end
					end
				ST_SELECT:
					if (|btn_edge || chord)
					begin
						sel_cnt <= 16'h0000;
						if (btn_edge[0])
							unique case (pending) // [RULE21]
								MODE_AUTO: pending <= MODE_MAN;
								MODE_MAN: pending <= MODE_OFF;
								MODE_OFF: pending <= MODE_AUTO;
							endcase
					end
					else if (tick)
					begin
						sel_cnt <= sel_cnt + 16'h0001;
						if (sel_cnt + 16'h0001 >= IDLE_TICKS)
						begin
							mode <= pending; // [RULE21]
							state <= ST_HOME;
						end
					end
			endcase
		end
	end

	// ********************************
	// Working output and panel lamps
	// ********************************
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			WORKING_OUTPUT <= 16'h0000;
			ramping <= 1'b0;
		end
		else if (SENSOR_OPEN)
			WORKING_OUTPUT <= ctrl[15:0]; // [RULE6]
		else
			unique case (mode)
				MODE_MAN:
				begin
					ramping <= 1'b1;
					if (tick && BTN_RAISE && WORKING_OUTPUT != OUT_MAX)
						WORKING_OUTPUT <= WORKING_OUTPUT + OUT_STEP; // [RULE18]
					else if (tick && BTN_LOWER && WORKING_OUTPUT != 16'h0000)
						WORKING_OUTPUT <= WORKING_OUTPUT - OUT_STEP; // [RULE18]
				end
				MODE_OFF:
					ramping <= 1'b1;
				MODE_AUTO:
					if (!ramping || WORKING_OUTPUT == AUTO_DEMAND)
					begin
						ramping <= 1'b0;
						WORKING_OUTPUT <= AUTO_DEMAND;
					end
					else if (tick)
						WORKING_OUTPUT <= (WORKING_OUTPUT < AUTO_DEMAND) ? // [RULE22]
							WORKING_OUTPUT + OUT_STEP : WORKING_OUTPUT - OUT_STEP;
			endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			OUTPUT_ONE_INDICATOR <= 1'b0;
			OUTPUT_TWO_INDICATOR <= 1'b0;
			OUTPUT_THREE_INDICATOR <= 1'b0;
			OUTPUT_FOUR_INDICATOR <= 1'b0;
			ALT_SETPOINT_INDICATOR <= 1'b0;
			REMOTE_SETPOINT_INDICATOR <= 1'b0;
			RUN_INDICATOR <= 1'b0;
			MANUAL_INDICATOR <= 1'b0;
			MODE_SELECT_DISPLAY <= 1'b0;
			LOOP_MODE <= MODE_AUTO;
			HEAT_COOL_ENABLE <= 1'b0;
			RETRANSMIT_ENABLE <= 1'b0;
			TUNE_TIMER_ENABLE <= 1'b0;
		end
		else
		begin
			OUTPUT_ONE_INDICATOR <= OUTPUT_ON[0]; // [RULE15]
			OUTPUT_TWO_INDICATOR <= OUTPUT_ON[1]; // [RULE15]
			OUTPUT_THREE_INDICATOR <= OUTPUT_ON[2]; // [RULE15]
			OUTPUT_FOUR_INDICATOR <= OUTPUT_ON[3]; // [RULE15]
			ALT_SETPOINT_INDICATOR <= ALT_SETPOINT_IN_USE; // [RULE15]
			REMOTE_SETPOINT_INDICATOR <= COMMS_ACTIVE ? blink : REMOTE_SETPOINT_IN_USE; // [RULE16]
			RUN_INDICATOR <= TIMER_RUNNING || (TIMER_HELD && blink); // [RULE17]
			MANUAL_INDICATOR <= (mode == MODE_MAN); // [RULE17]
			MODE_SELECT_DISPLAY <= (state == ST_SELECT);
			LOOP_MODE <= mode;
			HEAT_COOL_ENABLE <= (mode != MODE_OFF); // [RULE19]
			RETRANSMIT_ENABLE <= 1'b1; // [RULE19]
			TUNE_TIMER_ENABLE <= (mode == MODE_AUTO); // [RULE18]
		end
	end

	// ********************************
	// Checks
	// ********************************
	chk_beacon_flash: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE7]
		any_new |=> flashing) else $error("new alarm did not start flashing");
	chk_ack_steady: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE9]
		(ack && !any_new && any_active && !(ctrl[CTRL_REMOTE_EN_BIT] && REMOTE_INPUT_OPEN))
		|=> !flashing ##1 ALARM_BEACON == $past(any_active)) else $error("beacon not steady after ack");
	chk_off_heat: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE19]
		mode == MODE_OFF |=> !HEAT_COOL_ENABLE && RETRANSMIT_ENABLE) else $error("heat/cool active in off");
	chk_sensor_safe: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE6]
		SENSOR_OPEN |=> WORKING_OUTPUT == $past(ctrl[15:0])) else $error("safe output not applied");
	chk_entry_home: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE20]
		(state == ST_HOME && !HOME_DISPLAY) |=> state == ST_HOME) else $error("mode entry off home display");
	chk_mode_apply: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE21]
		(state == ST_SELECT && tick && !(|btn_edge) && !chord && sel_cnt + 16'h0001 >= IDLE_TICKS)
		|=> state == ST_HOME && mode == $past(pending)) else $error("selected mode not applied");
	chk_bumpless_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE22]
		(mode == MODE_MAN && !SENSOR_OPEN && !(tick && (BTN_RAISE || BTN_LOWER)))
		|=> WORKING_OUTPUT == $past(WORKING_OUTPUT)) else $error("output moved in manual without a button");
	chk_relay_polarity: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // [RULE8]
		(active[0] && !alm_cfg[0][ALM_ENERGISE_BIT]) |=> !ALARM_RELAY[0]) else $error("relay polarity wrong");
	cov_mode_select: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) state == ST_SELECT);
	cov_manual: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) mode == MODE_MAN);
	cov_loop_break: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) loop_break);
endmodule
`default_nettype wire

//--- panel_pkg.sv
`default_nettype none
package panel_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_US * (CLK_HZ / 1_000_000);
	localparam int MODE_HOLD_MS = 1000;
	localparam int MODE_IDLE_MS = 2000;
	localparam int FLASH_HALF_MS = 500;
	localparam int RATE_WINDOW_MS = 60000;
	localparam logic [15:0] HOLD_TICKS = 16'(MODE_HOLD_MS * 1000 / TICK_TIME_US);
	localparam logic [15:0] IDLE_TICKS = 16'(MODE_IDLE_MS * 1000 / TICK_TIME_US);
	localparam logic [15:0] FLASH_TICKS = 16'(FLASH_HALF_MS * 1000 / TICK_TIME_US);
	localparam int RATE_TICKS_DEF = RATE_WINDOW_MS * 1000 / TICK_TIME_US;
	localparam int ALARM_COUNT = 4;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LOOP_DELAY = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_OUTPUT = 8'h0c;
	localparam logic [7:0] ADDR_ALARM_BASE = 8'h10;
	localparam int CTRL_REMOTE_EN_BIT = 16;
	localparam int STATUS_ACK_BIT = 0;
	localparam int ALM_TYPE_LSB = 16;
	localparam int ALM_LATCH_LSB = 20;
	localparam int ALM_ENERGISE_BIT = 24;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] LOOP_DELAY_RESET = 16'h2710;
	localparam logic [31:0] ALM_CFG_RESET = 32'h0007_0000;
	localparam logic [15:0] OUT_STEP = 16'h0001;
	localparam logic [15:0] OUT_MAX = 16'hffff;
	typedef enum logic [2:0] {AL_HIGH = 3'h0, AL_LOW = 3'h1, AL_DEV_HIGH = 3'h2, AL_DEV_LOW = 3'h3,
		AL_BAND = 3'h4, AL_RISE = 3'h5, AL_FALL = 3'h6, AL_NONE = 3'h7} alarm_kind_type;
	typedef enum logic [1:0] {LATCH_NONE = 2'h0, LATCH_AUTO = 2'h1, LATCH_MANUAL = 2'h2} latch_type;
	typedef enum logic [2:0] {MODE_AUTO = 3'b001, MODE_MAN = 3'b010, MODE_OFF = 3'b100} mode_type;
	typedef enum logic [2:0] {ST_HOME = 3'b001, ST_HOLD = 3'b010, ST_SELECT = 3'b100} panel_state_type;
	function automatic logic signed [17:0] sdiff(input logic [15:0] a, input logic [15:0] b);
		sdiff = {a[15], a[15], a} - {b[15], b[15], b};
	endfunction
	function automatic logic signed [17:0] sext(input logic [15:0] a);
		sext = {a[15], a[15], a};
	endfunction
endpackage
`default_nettype wire

//--- alarm_latch.sv
`timescale 1ns/1ns
`default_nettype none
module alarm_latch
	import panel_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cond,
	input wire logic ack,
	input wire logic [1:0] latch_mode,
	output logic active,
	output logic new_alarm
);
	logic acked;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			active <= 1'b0;
			acked <= 1'b0;
		end
		else if (latch_mode == LATCH_NONE)
		begin
			active <= cond; // [RULE10]
			acked <= 1'b0;
		end
		else if (cond)
		begin
			active <= 1'b1;
			acked <= (latch_mode == LATCH_AUTO) && (acked || (ack && active)); // [RULE11] [RULE12]
		end
		else if (active && (ack || acked))
		begin
			active <= 1'b0; // [RULE11] [RULE12]
			acked <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			new_alarm <= 1'b0;
		else
			new_alarm <= cond && !active;
	end

	chk_nonlatch_clear: assert property (@(posedge clk) disable iff (rst) // [RULE10]
		(latch_mode == LATCH_NONE && !cond) |=> !active) else $error("non-latching alarm did not clear");
	chk_manual_ignore: assert property (@(posedge clk) disable iff (rst) // [RULE12]
		(latch_mode == LATCH_MANUAL && active && cond ##1 latch_mode == LATCH_MANUAL && !cond && !ack)
		|=> active) else $error("manual latch cleared without late acknowledge");
	chk_auto_remember: assert property (@(posedge clk) disable iff (rst) // [RULE11]
		(latch_mode == LATCH_AUTO && active && cond && ack ##1 latch_mode == LATCH_AUTO && !cond)
		|=> !active) else $error("early acknowledge not remembered");
	cov_manual_clear: cover property (@(posedge clk) disable iff (rst)
		latch_mode == LATCH_MANUAL && active ##1 !active);
endmodule
`default_nettype wire

//--- operator_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Front-panel operator
// ****************************************
module operator_model
#(
	parameter int HOLD_CYCLES = 10
)
(
	input wire logic clk,
	input wire logic chord_go,
	input wire logic lower_go,
	output logic btn_page,
	output logic btn_scroll,
	output logic btn_lower
);
	int hold_left = 0;
	// A chord request is held for the whole hold time before release
	always @(posedge clk)
	begin
		if (chord_go)
			hold_left <= HOLD_CYCLES;
		else if (hold_left > 0)
			hold_left <= hold_left - 1;
		btn_page <= chord_go || hold_left > 1;
		btn_scroll <= chord_go || hold_left > 1;
		btn_lower <= lower_go;
	end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import panel_pkg::*;
;
	localparam int TK = 10;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sens = 0, alt = 0, rsp = 0, trun = 0, home = 1, rin = 0;
	logic chord_go = 0, lower_go = 0, bp, bs, bl, pready, pslverr, beacon, sbm, hce, tte, rte, lbm;
	logic i1, i2, i3, i4, ai, ri, ru, mi, msel;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 32'hb8d5fad1;
	logic [15:0] pv = 0, dem = 0, wout;
	logic [3:0] outs = 0, relay, source;
	logic [2:0] mode;
	int err_total = 0, comparisons = 0, qc[$];
	logic [31:0] qe[$];
	string names[14] = '{"source", "relay", "beacon", "mode", "select", "indicators", "prdata", "pslverr",
		"output", "sensor_msg", "heat_cool", "tune_timer", "retransmit", "loop_msg"};
	event ev;
	always #4 clk = ~clk;
	alarm_panel #(.TICK_CYCLES(TK), .RATE_TICKS(20)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PROCESS_VALUE(pv), .SETPOINT_VALUE(16'h0000), .AUTO_DEMAND(dem),
		.SENSOR_OPEN(sens), .REMOTE_INPUT_OPEN(rin), .OUTPUT_ON(outs), .ALT_SETPOINT_IN_USE(alt),
		.REMOTE_SETPOINT_IN_USE(rsp), .COMMS_ACTIVE(1'b0), .TIMER_RUNNING(trun), .TIMER_HELD(1'b0),
		.HOME_DISPLAY(home), .BTN_PAGE(bp), .BTN_SCROLL(bs), .BTN_RAISE(1'b0), .BTN_LOWER(bl),
		.ALARM_BEACON(beacon), .ALARM_RELAY(relay), .ALARM_SOURCE(source), .LOOP_BREAK_MESSAGE(lbm),
		.SENSOR_BREAK_MESSAGE(sbm), .OUTPUT_ONE_INDICATOR(i1), .OUTPUT_TWO_INDICATOR(i2),
		.OUTPUT_THREE_INDICATOR(i3), .OUTPUT_FOUR_INDICATOR(i4), .ALT_SETPOINT_INDICATOR(ai),
		.REMOTE_SETPOINT_INDICATOR(ri), .RUN_INDICATOR(ru), .MANUAL_INDICATOR(mi),
		.MODE_SELECT_DISPLAY(msel), .LOOP_MODE(mode), .WORKING_OUTPUT(wout), .HEAT_COOL_ENABLE(hce),
		.RETRANSMIT_ENABLE(rte), .TUNE_TIMER_ENABLE(tte));
	operator_model #(.HOLD_CYCLES(1000 * TK + 50)) PARTNER (.clk(clk), .chord_go(chord_go),
		.lower_go(lower_go), .btn_page(bp), .btn_scroll(bs), .btn_lower(bl));
	// ****************************************
	// Checking
	// ****************************************
	function automatic logic [31:0] observe(input int c);
		case (c)
			0: return 32'(source);
			1: return 32'(relay);
			2: return 32'(beacon);
			3: return 32'(mode);
			4: return 32'(msel);
			5: return {24'h0, i4, i3, i2, i1, ai, ri, ru, mi};
			6: return prdata;
			7: return 32'(pslverr);
			8: return 32'(wout);
			9: return 32'(sbm);
			10: return 32'(hce);
			12: return 32'(rte);
			13: return 32'(lbm);
			default: return 32'(tte);
		endcase
	endfunction
	task automatic check(input int c, input logic [31:0] exp);
		logic [31:0] seen;
		seen = observe(c);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", names[c], exp, seen);
		end
	endtask
	// Outputs are compared at the falling edge, away from the edge that launches them
	always @(ev)
	begin
		@(negedge clk);
		while (qc.size() > 0)
			check(qc.pop_front(), qe.pop_front());
	end
	task automatic note(input int c, input logic [31:0] e);
		qc.push_back(c);
		qe.push_back(e);
		->ev;
	endtask
	task automatic summarize;
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************************************
	// Stimulus
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			if (++n > 50)
			begin
				err_total++;
				summarize();
			end
		end
		while (pready !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
		if (!wr)
			note(6, e);
		note(7, 32'(err));
	endtask
	task automatic push(input logic c);
		if (c)
			chord_go <= 1'b1;
		else
			lower_go <= 1'b1;
		step(3);
		chord_go <= 1'b0;
		lower_go <= 1'b0;
	endtask
	initial
	begin
		step(5);
		rst <= 1'b0;
		step(4);
		note(3, 32'(MODE_AUTO));
		note(1, 32'hf);
		apb(0, ADDR_ALARM_BASE + 8'h0c, 0, ALM_CFG_RESET, 0);
		apb(0, 8'h40, 0, 0, 1);
		apb(1, 8'h44, 32'h1, 0, 1);
		for (int t = 0; t < 5; t++)
			for (int k = 0; k < 3; k++)
			begin
				apb(1, ADDR_ALARM_BASE, {7'h0, (t == 4), 5'h0, 3'(t), (t == 1) ? 16'hfff6 : 16'h000a}, 0, 0);
				pv <= (k != 1) ? 16'h0000 : (t[0] || t == 4) ? 16'hffec : 16'h0014;
				step(5);
				note(0, 32'(k == 1));
				note(1, {31'h7, (k == 1) == (t == 4)});
			end
		for (int d = 0; d < 2; d++)
		begin
			apb(1, ADDR_ALARM_BASE, d ? 32'h0006_000a : 32'h0005_000a, 0, 0);
			repeat (450)
			begin
				pv <= d ? pv - 16'h0001 : pv + 16'h0001;
				step(1);
			end
			note(0, 32'h1);
		end
		for (int l = 0; l < 3; l++)
		begin
			apb(1, ADDR_ALARM_BASE, {10'h0, 2'(l), 4'h0, 16'h000a}, 0, 0);
			pv <= 16'h0014;
			step(5);
			apb(1, ADDR_STATUS, 32'h1, 0, 0);
			step(5);
			note(2, 32'h1);
			pv <= 16'h0000;
			step(5);
			note(0, 32'(l == 2));
			apb(1, ADDR_STATUS, 32'h1, 0, 0);
			step(5);
			note(0, 32'h0);
			note(2, 32'h0);
		end
		apb(1, ADDR_CTRL, 32'h1234, 0, 0);
		apb(0, ADDR_CTRL, 0, 32'h1234, 0);
		sens <= 1'b1;
		step(5);
		note(8, 32'h1234);
		note(9, 32'h1);
		sens <= 1'b0;
		apb(1, ADDR_CTRL, 32'h0001_1234, 0, 0);
		note(2, 32'h0);
		rin <= 1'b1;
		step(5);
		note(2, 32'h1);
		rin <= 1'b0;
		for (int r = 0; r < 4; r++)
		begin
			seed = xs(seed);
			{dem, trun, rsp, alt, outs} <= {seed[31:16], seed[6:0]};
			step(5);
			note(5, {24'h0, seed[3:0], seed[4], seed[5], seed[6], 1'b0});
		end
		apb(1, ADDR_LOOP_DELAY, 32'h5, 0, 0);
		dem <= ~dem;
		step(100);
		note(13, 32'h1);
		pv <= 16'h0001;
		step(5);
		note(13, 32'h0);
		apb(1, ADDR_LOOP_DELAY, 32'(LOOP_DELAY_RESET), 0, 0);
		home <= 1'b0;
		push(1);
		step(1000 * TK + 100);
		note(4, 32'h0);
		home <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			push(1);
			step(1000 * TK + 100);
			note(4, 32'h1);
			push(0);
			step(2000 * TK + 200);
			note(4, 32'h0);
			note(3, 32'((m == 0) ? MODE_MAN : MODE_OFF));
			note(11, 32'h0);
			note(5, {24'h0, seed[3:0], seed[4], seed[5], seed[6], 1'(m == 0)});
		end
		note(3, 32'(MODE_OFF));
		note(10, 32'h0);
		note(11, 32'h0);
		note(5, {24'h0, seed[3:0], seed[4], seed[5], seed[6], 1'b0});
		note(12, 32'h1);
		apb(0, ADDR_STATUS, 0, {20'h00000, ST_HOME, MODE_OFF, 6'h00}, 0);
		step(2);
		summarize();
	end
endmodule
`default_nettype wire
